// ===== dv/tb_top.sv
// self-checking bench for the reference priority register block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rip_pkg::*;
    // ****************
    // stimulus and dut
    // ****************
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    rip_byte_type wdata = 8'h00;
    logic strap = 1'b0;
    logic sel = 1'b0;
    logic [7:0] rdata;
    logic rd_valid;
    logic [15:0] main_prio;
    logic [15:0] aux_prio;
    logic [3:0] main_elig;
    logic [3:0] aux_elig;
    int mismatches = 0;
    int total_checks = 0;
    // each row is bank select, offset, byte written and read back
    logic [16:0] rows [4] = '{{1'b0, 8'h1D, 8'h35}, {1'b1, 8'h1D, 8'h7A},
                              {1'b0, 8'h1E, 8'h0F}, {1'b1, 8'h1E, 8'hF0}};

    always #50 core_clk = ~core_clk;

    rip_priority_regs i_rip_priority_regs (
        .core_clk(core_clk), .srst(srst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
        .wdata(wdata), .rdata(rdata), .rd_valid(rd_valid), .master_slave_strap(strap),
        .path_bank_select(sel), .main_prio(main_prio), .aux_prio(aux_prio),
        .main_eligible(main_elig), .aux_eligible(aux_elig)
    );

    // ****************
    // tasks
    // ****************
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // an idle cycle follows each access so no strobe is lowered and raised in one step
    task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] d);
        sel = s;
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(posedge core_clk);
        #1;
        wr_en = 1'b0;
        @(posedge core_clk);
        #1;
    endtask

    task automatic rd(input logic s, input logic [7:0] a, input logic [7:0] exp);
        sel = s;
        addr = a;
        rd_en = 1'b1;
        @(posedge core_clk);
        #1;
        rd_en = 1'b0;
        chk(16'(rd_valid), 16'h0001, "read valid");
        chk(16'(rdata), 16'(exp), "read data");
        @(posedge core_clk);
        #1;
        chk(16'(rd_valid), 16'h0000, "read valid drop");
    endtask

    task automatic rst(input logic s);
        srst = 1'b1;
        strap = s;
        repeat (20) @(posedge core_clk);
        #1;
        chk(main_prio, 16'hFEDC, "main reset");
        chk(aux_prio, 16'h0000, "aux reset");
        chk(16'({main_elig, aux_elig}), 16'h00F0, "eligible reset");
        srst = 1'b0;
    endtask

    // ****************
    // sequence
    // ****************
    initial begin
        rst(1'b0);
        repeat (2) @(posedge core_clk);
        #1;
        chk(16'(main_prio[3:0]), 16'h0001, "slave default");
        rd(1'b0, 8'h1D, 8'hD1);
        rd(1'b0, 8'h1E, 8'hFE);
        rd(1'b1, 8'h1D, 8'h00);
        for (int i = 0; i < 4; i++) wr(rows[i][16], rows[i][15:8], rows[i][7:0]);
        for (int i = 0; i < 4; i++) rd(rows[i][16], rows[i][15:8], rows[i][7:0]);
        chk(main_prio, 16'h0F35, "main outputs");
        chk(aux_prio, 16'hF07A, "aux outputs");
        chk(16'(main_elig), 16'h0007, "main eligible");
        chk(16'(aux_elig), 16'h000B, "aux eligible");
        // unmapped offset: write ignored, read gives zero
        wr(1'b0, 8'h1F, 8'hAA);
        rd(1'b0, 8'h1F, 8'h00);
        chk(main_prio, 16'h0F35, "unmapped write leak");
        // read and write together return the old byte
        sel = 1'b0;
        addr = 8'h1E;
        wdata = 8'h44;
        wr_en = 1'b1;
        rd_en = 1'b1;
        @(posedge core_clk);
        #1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        chk(16'(rdata), 16'h000F, "same cycle read");
        @(posedge core_clk);
        #1;
        rd(1'b0, 8'h1E, 8'h44);
        rst(1'b1);
        repeat (3) @(posedge core_clk);
        #1;
        rd(1'b0, 8'h1D, 8'hDC);
        // a write in the first cycle after release beats the strap default
        rst(1'b0);
        wr(1'b0, 8'h1D, 8'h22);
        rd(1'b0, 8'h1D, 8'h22);
        test_done;
    end

    initial begin
        #100000;
        mismatches++;
        test_done;
    end
endmodule
`default_nettype wire

// ===== logic/rip_bank.sv
// two-bank priority storage with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "rip_map.svh"
module rip_bank (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // storage port
    rip_bank_if.mem bus
);
    import rip_pkg::*;

    wire rip_byte_type main_sel = bus.main_q[bus.rd_idx];
    wire rip_byte_type aux_sel = bus.aux_q[bus.rd_idx];
    wire rip_byte_type next_rd_data = !bus.rd_hit ? `RIP_READ_MISS :
        (bus.rd_bank == RIP_BANK_AUX) ? aux_sel : main_sel;
    wire main_wr = bus.wr_en && (bus.wr_bank == RIP_BANK_MAIN);
    wire aux_wr = bus.wr_en && (bus.wr_bank == RIP_BANK_AUX);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            bus.main_q <= {`RIP_RST_13_14, `RIP_RST_11_12};
        end else begin
            // software write in the same cycle overrides the strap fix
            if (bus.fix_en) begin
                bus.main_q[0][`RIP_LO_MSB:`RIP_LO_LSB] <= `RIP_PRIO_SLAVE;
            end
            if (main_wr) begin
                bus.main_q[bus.wr_idx] <= bus.wr_data;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            bus.aux_q <= {`RIP_RST_AUX, `RIP_RST_AUX};
        end else if (aux_wr) begin
            bus.aux_q[bus.wr_idx] <= bus.wr_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            bus.rd_data <= `RIP_READ_MISS;
        end else if (bus.rd_en) begin
            bus.rd_data <= next_rd_data;
        end
    end
endmodule
`default_nettype wire

// ===== logic/rip_bank_if.sv
// signals between the register front end and the priority storage
`timescale 1ns/1ps
`default_nettype none
interface rip_bank_if;
    import rip_pkg::*;
    logic wr_en;
    rip_bank_type wr_bank;
    logic wr_idx;
    rip_byte_type wr_data;
    logic fix_en;
    logic rd_en;
    logic rd_hit;
    rip_bank_type rd_bank;
    logic rd_idx;
    rip_byte_type rd_data;
    logic [1:0][7:0] main_q;
    logic [1:0][7:0] aux_q;
    modport ctl (output wr_en, wr_bank, wr_idx, wr_data, fix_en, rd_en, rd_hit, rd_bank, rd_idx,
                 input rd_data, main_q, aux_q);
    modport mem (input wr_en, wr_bank, wr_idx, wr_data, fix_en, rd_en, rd_hit, rd_bank, rd_idx,
                 output rd_data, main_q, aux_q);
endinterface
`default_nettype wire

// ===== logic/rip_map.svh
// register offsets, field positions and reset values of the reference priority registers
// Notes on behaviour
// - byte 1D: input 11 low, 12 high
// - byte 1E: input 13 low, 14 high
// - zero excludes input; smaller number ranks higher
// - strap high gives main input 11 twelve, low one
// - path select bit picks main or aux settings
`ifndef RIP_MAP_SVH
`define RIP_MAP_SVH

`define RIP_OFS_11_12 8'h1D
`define RIP_OFS_13_14 8'h1E
`define RIP_RST_11_12 8'hDC
`define RIP_RST_13_14 8'hFE
`define RIP_RST_AUX 8'h00
`define RIP_PRIO_OFF 4'h0
`define RIP_PRIO_MASTER 4'hC
`define RIP_PRIO_SLAVE 4'h1
`define RIP_LO_MSB 3
`define RIP_LO_LSB 0
`define RIP_HI_MSB 7
`define RIP_HI_LSB 4
`define RIP_READ_MISS 8'h00

`endif

// ===== logic/rip_pkg.sv
// types shared by the reference priority register block
package rip_pkg;
    typedef logic [3:0] rip_prio_type;
    typedef logic [7:0] rip_byte_type;
    typedef enum logic {
        RIP_BANK_MAIN = 1'b0,
        RIP_BANK_AUX = 1'b1
    } rip_bank_type;
    typedef enum logic {
        RIP_ST_STRAP = 1'b0,
        RIP_ST_RUN = 1'b1
    } rip_state_type;
endpackage

// ===== logic/rip_priority_regs.sv
// reference priority registers for inputs eleven to fourteen, main and aux paths
`timescale 1ns/1ps
`default_nettype none
`include "rip_map.svh"
module rip_priority_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // microprocessor port
    input wire logic [7:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire rip_pkg::rip_byte_type wdata,
    output logic [7:0] rdata,
    output logic rd_valid,
    // strap pin and path select bit
    input wire logic master_slave_strap,
    input wire logic path_bank_select,
    // priorities to the selection logic, nibble n is input 11+n
    output logic [15:0] main_prio,
    output logic [15:0] aux_prio,
    output logic [3:0] main_eligible,
    output logic [3:0] aux_eligible
);
    import rip_pkg::*;

    // ************************************************************
    // address decode
    // ************************************************************
    wire hit_11_12 = (addr == `RIP_OFS_11_12);
    wire hit_13_14 = (addr == `RIP_OFS_13_14);
    wire hit = hit_11_12 || hit_13_14;
    wire rip_bank_type sel_bank = path_bank_select ? RIP_BANK_AUX : RIP_BANK_MAIN;
    wire reg_idx = hit_13_14;

    rip_bank_if bus ();

    assign bus.wr_en = wr_en && hit;
    assign bus.wr_bank = sel_bank;
    assign bus.wr_idx = reg_idx;
    assign bus.wr_data = wdata;
    assign bus.rd_en = rd_en;
    assign bus.rd_hit = hit;
    assign bus.rd_bank = sel_bank;
    assign bus.rd_idx = reg_idx;
    assign rdata = bus.rd_data;

    rip_bank i_rip_bank (
        .core_clk(core_clk),
        .srst(srst),
        .bus(bus)
    );

    // ************************************************************
    // strap capture
    // ************************************************************
    // the strap is an asynchronous pin; the synchroniser runs through reset
    logic strap_meta;
    logic strap_sync;
    always_ff @(posedge core_clk) begin
        strap_meta <= master_slave_strap;
        strap_sync <= strap_meta;
    end

    rip_state_type state;
    rip_state_type next_state;
    always_comb begin
        case (state)
            RIP_ST_STRAP: next_state = RIP_ST_RUN;
            RIP_ST_RUN: next_state = RIP_ST_RUN;
            default: next_state = RIP_ST_STRAP;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= RIP_ST_STRAP;
        end else begin
            state <= next_state;
        end
    end

    assign bus.fix_en = (state == RIP_ST_STRAP) && !srst && !strap_sync;

    // ************************************************************
    // outputs to selection logic
    // ************************************************************
    wire [15:0] next_main_prio = {bus.main_q[1], bus.main_q[0]};
    wire [15:0] next_aux_prio = {bus.aux_q[1], bus.aux_q[0]};
    logic [3:0] next_main_elig;
    logic [3:0] next_aux_elig;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            next_main_elig[i] = (next_main_prio[4*i +: 4] != `RIP_PRIO_OFF);
            next_aux_elig[i] = (next_aux_prio[4*i +: 4] != `RIP_PRIO_OFF);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            main_prio <= {`RIP_RST_13_14, `RIP_RST_11_12};
            aux_prio <= {`RIP_RST_AUX, `RIP_RST_AUX};
            main_eligible <= 4'hF;
            aux_eligible <= 4'h0;
            rd_valid <= 1'b0;
        end else begin
            main_prio <= next_main_prio;
            aux_prio <= next_aux_prio;
            main_eligible <= next_main_elig;
            aux_eligible <= next_aux_elig;
            rd_valid <= rd_en;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    wire main_wr_11 = wr_en && hit_11_12 && !path_bank_select;

    wr_main_a: assert property (
        @(posedge core_clk) disable iff (srst)
        main_wr_11 |=> bus.main_q[0] == $past(wdata) ##1 main_prio[7:0] == $past(wdata, 2))
        else $error("main write to input 11/12 not stored");

    wr_aux_a: assert property (
        @(posedge core_clk) disable iff (srst)
        wr_en && hit_13_14 && path_bank_select |=> bus.aux_q[1] == $past(wdata))
        else $error("aux write to input 13/14 not stored");

    bank_iso_a: assert property (
        @(posedge core_clk) disable iff (srst)
        wr_en && path_bank_select && !bus.fix_en |=> $stable(bus.main_q))
        else $error("aux write disturbed main bank");

    path_sel_a: assert property (
        @(posedge core_clk) disable iff (srst)
        wr_en && hit && !path_bank_select |=> $stable(bus.aux_q))
        else $error("main write disturbed aux bank");

    rd_sel_a: assert property (
        @(posedge core_clk) disable iff (srst)
        rd_en && hit_13_14 && path_bank_select |=> rd_valid && rdata == $past(bus.aux_q[1]))
        else $error("read did not return selected bank");

    rd_miss_a: assert property (
        @(posedge core_clk) disable iff (srst)
        rd_en && !hit |=> rd_valid && rdata == `RIP_READ_MISS)
        else $error("unmapped read not zero");

    excl_flag_a: assert property (
        @(posedge core_clk) disable iff (srst)
        main_eligible[0] == (main_prio[3:0] != `RIP_PRIO_OFF)
        && aux_eligible[3] == (aux_prio[15:12] != `RIP_PRIO_OFF))
        else $error("eligibility does not follow priority field");

    strap_slave_a: assert property (
        @(posedge core_clk) disable iff (srst)
        $fell(srst) && !strap_sync && !main_wr_11 |=> bus.main_q[0][3:0] == `RIP_PRIO_SLAVE)
        else $error("slave strap default not applied");

    strap_master_a: assert property (
        @(posedge core_clk) disable iff (srst)
        $fell(srst) && strap_sync && !main_wr_11 |=> bus.main_q[0][3:0] == `RIP_PRIO_MASTER)
        else $error("master strap default lost");

    wr_main_hi_a: assert property (
        @(posedge core_clk) disable iff (srst)
        wr_en && hit_13_14 && !path_bank_select |=> bus.main_q[1] == $past(wdata))
        else $error("main write to input 13/14 not stored");

    wr_aux_lo_a: assert property (
        @(posedge core_clk) disable iff (srst)
        wr_en && hit_11_12 && path_bank_select |=> bus.aux_q[0] == $past(wdata))
        else $error("aux write to input 11/12 not stored");

    wr_miss_a: assert property (
        @(posedge core_clk) disable iff (srst)
        wr_en && !hit && !bus.fix_en |=> $stable(bus.main_q) && $stable(bus.aux_q))
        else $error("unmapped write changed a bank");

    rd_main_a: assert property (
        @(posedge core_clk) disable iff (srst)
        rd_en && hit_11_12 && !path_bank_select |=> rdata == $past(bus.main_q[0]))
        else $error("read did not return main bank");

    rd_pulse_a: assert property (
        @(posedge core_clk) disable iff (srst)
        !rd_en |=> !rd_valid)
        else $error("read valid without a read strobe");

    rd_hold_a: assert property (
        @(posedge core_clk) disable iff (srst)
        !rd_en |=> $stable(rdata))
        else $error("read data changed without a read");

    out_track_a: assert property (
        @(posedge core_clk) disable iff (srst)
        !$past(srst) |-> main_prio == $past(bus.main_q) && aux_prio == $past(bus.aux_q))
        else $error("priority outputs do not follow storage");

    elig_main_a: assert property (
        @(posedge core_clk) disable iff (srst)
        main_eligible == {main_prio[15:12] != `RIP_PRIO_OFF, main_prio[11:8] != `RIP_PRIO_OFF,
            main_prio[7:4] != `RIP_PRIO_OFF, main_prio[3:0] != `RIP_PRIO_OFF})
        else $error("main eligibility does not follow priority fields");

    elig_aux_a: assert property (
        @(posedge core_clk) disable iff (srst)
        aux_eligible == {aux_prio[15:12] != `RIP_PRIO_OFF, aux_prio[11:8] != `RIP_PRIO_OFF,
            aux_prio[7:4] != `RIP_PRIO_OFF, aux_prio[3:0] != `RIP_PRIO_OFF})
        else $error("aux eligibility does not follow priority fields");

    strap_once_a: assert property (
        @(posedge core_clk) disable iff (srst)
        !$past(srst) |-> !bus.fix_en)
        else $error("strap default applied after the first cycle");

    cov_main_wr: cover property (@(posedge core_clk) disable iff (srst) main_wr_11);
    cov_aux_rd: cover property (@(posedge core_clk) disable iff (srst)
        rd_en && hit && path_bank_select);
    cov_slave: cover property (@(posedge core_clk) disable iff (srst) bus.fix_en);
    cov_miss: cover property (@(posedge core_clk) disable iff (srst) rd_en && !hit);
    cov_master: cover property (@(posedge core_clk) disable iff (srst)
        $fell(srst) && strap_sync);
endmodule
`default_nettype wire
